// >>> common/ssc_pkg.sv
// shared constants and types for the stepper settings and chopper block
package ssc_pkg;
   localparam int unsigned CLK_HZ = 50000000;
   localparam int unsigned CHOP_FAST_HZ = 400000;
   localparam int unsigned CHOP_SLOW_HZ = 200000;
   localparam int unsigned CHOP_FAST_CYC = CLK_HZ / CHOP_FAST_HZ;
   localparam int unsigned CHOP_SLOW_CYC = CLK_HZ / CHOP_SLOW_HZ;
   localparam int unsigned CHOP_CNT_W = 9;
   localparam int unsigned FORCED_CYC_DEF = 10;
   localparam int unsigned SLOW_CYC_DEF = 40;
   localparam int unsigned POS_W = 8;
   localparam int unsigned STEPS_PER_FULL = 64;
   localparam int unsigned BITS_PER_BYTE = 8;
   // setting byte: [7:5] selects the setting, [3:0] carries its value
   localparam int unsigned SEL_MSB = 7;
   localparam int unsigned SEL_LSB = 5;
   localparam int unsigned VAL_MSB = 3;
   localparam logic [2:0] SEL_HOLD = 3'h0;
   localparam logic [2:0] SEL_CNT_RESET = 3'h1;
   localparam logic [2:0] SEL_DIVIDER = 3'h2;
   localparam logic [2:0] SEL_REF_12 = 3'h3;
   localparam logic [2:0] SEL_REF_34 = 3'h4;
   localparam logic [2:0] SEL_CHOP_FREQ = 3'h5;
   localparam logic [3:0] REF_CODE_RST = 4'h0;
   localparam logic [1:0] DIV_RST = 2'h0;
   localparam logic [7:0] REF_TOP_MV = 8'hC8;
   localparam logic [7:0] REF_STEP_MV = 8'h0A;

   typedef enum logic [1:0] {
      CH_FORCED,
      CH_CHARGE,
      CH_SLOW,
      CH_FAST
   } ssc_chop_e;

   // reference voltage in millivolts for a 4-bit setpoint code
   function automatic logic [7:0] ssc_ref_mv(input logic [3:0] code);
      logic [7:0] drop;
      drop = 8'(code) * REF_STEP_MV;
      return REF_TOP_MV - drop;
   endfunction
endpackage

// >>> rtl/ssc_byte_rx.sv
// serial byte receiver: shifts data on clock rises, flags each complete byte
`timescale 1ns/1ps
`default_nettype none
module ssc_byte_rx import ssc_pkg::*; (
   input wire logic clock,
   input wire logic reset,
   input wire logic frameStart,
   input wire logic sclRise,
   input wire logic sdaIn,
   output logic [7:0] rxByte,
   output logic rxDone
);
   typedef struct packed {
      logic [6:0] shift;
      logic [3:0] bitCount;
      logic [7:0] data;
      logic done;
   } ssc_rx_s;

   ssc_rx_s state;
   ssc_rx_s next_state;

   always_comb begin
      next_state = state;
      next_state.done = 1'b0;
      if (frameStart) begin
         next_state.bitCount = 4'h0;
      end else if (sclRise) begin
         // ninth rise is the acknowledge slot and carries no data
         if (state.bitCount == 4'(BITS_PER_BYTE)) begin
            next_state.bitCount = 4'h0;
         end else if (state.bitCount == 4'(BITS_PER_BYTE - 1)) begin
            next_state.data = {state.shift, sdaIn};
            next_state.done = 1'b1;
            next_state.bitCount = 4'(BITS_PER_BYTE);
         end else begin
            next_state.shift = {state.shift[5:0], sdaIn};
            next_state.bitCount = state.bitCount + 4'h1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign rxByte = state.data;
   assign rxDone = state.done;
endmodule
`default_nettype wire

// >>> rtl/ssc_stepper_chopper.sv
// settings decode, step clock hold and divide, micro-step position, chopper
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Writing hold freezes the internal step clock at the level the outside step clock had then.
// - While held the position counter does not move whatever the step clock does.
// - Hold set and clear both apply at the byte's eighth data clock rise.
// - Counter reset active puts the position back to the initial position at that rise.
// - After release, counting resumes on the first step clock rise that follows.
// - The position counts 256 steps per cycle, one step being 1/64 of a full step.
// - The step clock divider offers divide by 1, 2, 4 or 8.
// - A new ratio is taken at that rise and used from the next step clock edge.
// - The 4-bit reference code maps 0 to 0.200 V down to 15 at 0.050 V in 0.010 V steps.
// - Channels 1/2 and channels 3/4 each keep their own reference code.
// - A new reference code applies at the byte's eighth data clock rise.
// - Each chopping period starts in charge with a forced-charge interval comparing current.
// - If current was below setpoint in forced charge, charge until reached, then slow, then fast.
// - If current never was below setpoint in forced charge, fast decay to period end.
// - A chopping frequency change applies at the byte's eighth data clock rise.
module ssc_stepper_chopper import ssc_pkg::*; #(
   parameter int unsigned FORCED_CYC = FORCED_CYC_DEF,
   parameter int unsigned SLOW_CYC = SLOW_CYC_DEF
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic frameStart,
   input wire logic sclRise,
   input wire logic sdaIn,
   input wire logic stepClkIn,
   input wire logic coilBelowSetpoint,
   output logic internalStepClk,
   output logic holdActive,
   output logic counterResetActive,
   output logic [1:0] divRatioSel,
   output logic [POS_W-1:0] position,
   output logic [3:0] currentSetpoint12,
   output logic [3:0] currentSetpoint34,
   output logic [7:0] setpointMv12,
   output logic [7:0] setpointMv34,
   output logic chopFreqSlow,
   output logic chargeOn,
   output logic slowDecayOn,
   output logic fastDecayOn
);
   // zero lengths would underflow the phase compare; fast decay needs room too
   if (FORCED_CYC < 1 || SLOW_CYC < 1 || FORCED_CYC + SLOW_CYC >= CHOP_FAST_CYC) begin
      $error("forced and slow lengths must fit inside the shorter chopping period");
   end

   typedef struct packed {
      logic hold;
      logic heldLevel;
      logic cntReset;
      logic [1:0] divSel;
      logic [2:0] divCount;
      logic prevClk;
      logic [POS_W-1:0] pos;
      logic [3:0] ref12;
      logic [3:0] ref34;
      logic [7:0] mv12;
      logic [7:0] mv34;
      logic freqSlow;
      logic [CHOP_CNT_W-1:0] chopCount;
      logic [CHOP_CNT_W-1:0] phaseCount;
      logic sawBelow;
      ssc_chop_e chop;
   } ssc_state_s;

   ssc_state_s state;
   ssc_state_s next_state;
   logic [7:0] rxByte;
   logic rxDone;
   logic [2:0] rxSel;
   logic [3:0] rxVal;
   logic clkNow;
   logic clkRise;
   logic [2:0] divLast;
   logic [CHOP_CNT_W-1:0] periodLast;
   logic periodEnd;

   ssc_byte_rx ssc_byte_rx_i (
      .clock(clock),
      .reset(reset),
      .frameStart(frameStart),
      .sclRise(sclRise),
      .sdaIn(sdaIn),
      .rxByte(rxByte),
      .rxDone(rxDone)
   );

   assign rxSel = rxByte[SEL_MSB:SEL_LSB];
   assign rxVal = rxByte[VAL_MSB:0];
   // frozen level while held, live step clock otherwise
   assign clkNow = state.hold ? state.heldLevel : stepClkIn;
   assign clkRise = clkNow && !state.prevClk;
   // divide ratio 2^sel, counted as last index 2^sel - 1
   assign divLast = 3'((4'h1 << state.divSel) - 4'h1);
   assign periodLast = state.freqSlow ? CHOP_CNT_W'(CHOP_SLOW_CYC - 1)
                                      : CHOP_CNT_W'(CHOP_FAST_CYC - 1);
   // slow to fast switch may find the count already past the new end
   assign periodEnd = (state.chopCount >= periodLast);

   always_comb begin
      next_state = state;
      next_state.prevClk = clkNow;
      next_state.mv12 = ssc_ref_mv(state.ref12);
      next_state.mv34 = ssc_ref_mv(state.ref34);

      // step clock divide and position advance
      if (state.cntReset) begin
         next_state.pos = '0;
         next_state.divCount = 3'h0;
      end else if (clkRise && !state.hold) begin
         if (state.divCount >= divLast) begin
            next_state.divCount = 3'h0;
            next_state.pos = state.pos + POS_W'(1);
         end else begin
            next_state.divCount = state.divCount + 3'h1;
         end
      end

      // settings land on the byte that completes them
      if (rxDone) begin
         case (rxSel)
            SEL_HOLD: begin
               next_state.hold = rxVal[0];
               if (rxVal[0] && !state.hold) begin
                  next_state.heldLevel = stepClkIn;
               end
            end
            SEL_CNT_RESET: begin
               next_state.cntReset = rxVal[0];
               if (rxVal[0]) begin
                  next_state.pos = '0;
                  next_state.divCount = 3'h0;
               end
            end
            SEL_DIVIDER: begin
               // restart the divide so the new ratio counts from the next edge
               next_state.divSel = rxVal[1:0];
               next_state.divCount = 3'h0;
            end
            SEL_REF_12: begin
               next_state.ref12 = rxVal;
            end
            SEL_REF_34: begin
               next_state.ref34 = rxVal;
            end
            SEL_CHOP_FREQ: begin
               next_state.freqSlow = rxVal[0];
            end
            default: begin
            end
         endcase
      end

      // chopper
      if (periodEnd) begin
         next_state.chopCount = '0;
      end else begin
         next_state.chopCount = state.chopCount + CHOP_CNT_W'(1);
      end
      next_state.phaseCount = state.phaseCount + CHOP_CNT_W'(1);
      if (periodEnd) begin
         next_state.chop = CH_FORCED;
         next_state.phaseCount = '0;
         next_state.sawBelow = 1'b0;
      end else begin
         case (state.chop)
            CH_FORCED: begin
               if (coilBelowSetpoint) begin
                  next_state.sawBelow = 1'b1;
               end
               if (state.phaseCount == CHOP_CNT_W'(FORCED_CYC - 1)) begin
                  next_state.phaseCount = '0;
                  if (state.sawBelow || coilBelowSetpoint) begin
                     next_state.chop = CH_CHARGE;
                  end else begin
                     next_state.chop = CH_FAST;
                  end
               end
            end
            CH_CHARGE: begin
               if (!coilBelowSetpoint) begin
                  next_state.chop = CH_SLOW;
                  next_state.phaseCount = '0;
               end
            end
            CH_SLOW: begin
               if (state.phaseCount == CHOP_CNT_W'(SLOW_CYC - 1)) begin
                  next_state.chop = CH_FAST;
               end
            end
            CH_FAST: begin
               // stays until the period wraps
               next_state.chop = CH_FAST;
            end
            default: begin
               next_state.chop = CH_FORCED;
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         state <= '{
            hold: 1'b0,
            heldLevel: 1'b0,
            cntReset: 1'b0,
            divSel: DIV_RST,
            divCount: 3'h0,
            prevClk: 1'b0,
            pos: '0,
            ref12: REF_CODE_RST,
            ref34: REF_CODE_RST,
            mv12: REF_TOP_MV,
            mv34: REF_TOP_MV,
            freqSlow: 1'b0,
            chopCount: '0,
            phaseCount: '0,
            sawBelow: 1'b0,
            chop: CH_FORCED
         };
      end else begin
         state <= next_state;
      end
   end

   assign internalStepClk = state.prevClk;
   assign holdActive = state.hold;
   assign counterResetActive = state.cntReset;
   assign divRatioSel = state.divSel;
   assign position = state.pos;
   assign currentSetpoint12 = state.ref12;
   assign currentSetpoint34 = state.ref34;
   assign setpointMv12 = state.mv12;
   assign setpointMv34 = state.mv34;
   assign chopFreqSlow = state.freqSlow;
   assign chargeOn = (state.chop == CH_FORCED) || (state.chop == CH_CHARGE);
   assign slowDecayOn = (state.chop == CH_SLOW);
   assign fastDecayOn = (state.chop == CH_FAST);
endmodule
`default_nettype wire

// >>> dv/ssc_stepper_chopper_monitor.sv
// assertion checker for the stepper settings and chopper block
`timescale 1ns/1ps
`default_nettype none
module ssc_stepper_chopper_monitor import ssc_pkg::*; (
   input wire logic clock,
   input wire logic reset,
   input wire logic stepClkIn,
   input wire logic internalStepClk,
   input wire logic holdActive,
   input wire logic counterResetActive,
   input wire logic [1:0] divRatioSel,
   input wire logic [POS_W-1:0] position,
   input wire logic [3:0] currentSetpoint12,
   input wire logic [7:0] setpointMv12,
   input wire logic chargeOn,
   input wire logic slowDecayOn,
   input wire logic fastDecayOn
);
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   sequence s_held; holdActive ##1 holdActive; endsequence
   sequence s_slowEnd; slowDecayOn ##1 !slowDecayOn; endsequence
   property p_oneMode; $onehot({chargeOn, slowDecayOn, fastDecayOn}); endproperty
   a_oneMode: assert property (p_oneMode) else $error("mode not one-hot");
   property p_holdLevel; s_held |-> $stable(internalStepClk); endproperty
   a_holdLevel: assert property (p_holdLevel) else $error("held clock moved");
   // one cycle of slack: a rise sampled before hold lands may still count
   property p_holdPos; s_held |=> $stable(position); endproperty
   a_holdPos: assert property (p_holdPos) else $error("held position moved");
   property p_resetPos; counterResetActive |=> position == '0; endproperty
   a_resetPos: assert property (p_resetPos) else $error("position not cleared");
   property p_step;
      stepClkIn && !internalStepClk && divRatioSel == 2'h0 && !holdActive
      && !counterResetActive |=> position == $past(position) + 8'h01;
   endproperty
   a_step: assert property (p_step) else $error("step not taken");
   property p_mv12; 1'b1 |=> setpointMv12 == 8'hC8 - 8'h0A * {4'h0, $past(currentSetpoint12)};
   endproperty
   a_mv12: assert property (p_mv12) else $error("reference level wrong");
   property p_slowFast; s_slowEnd |-> fastDecayOn || chargeOn; endproperty
   a_slowFast: assert property (p_slowFast) else $error("slow not followed by fast");
   property p_fastHold; fastDecayOn |=> fastDecayOn || chargeOn; endproperty
   a_fastHold: assert property (p_fastHold) else $error("fast decay left early");
endmodule
bind ssc_stepper_chopper ssc_stepper_chopper_monitor ssc_stepper_chopper_monitor_i (
   .clock(clock), .reset(reset), .stepClkIn(stepClkIn), .internalStepClk(internalStepClk),
   .holdActive(holdActive), .counterResetActive(counterResetActive),
   .divRatioSel(divRatioSel), .position(position), .currentSetpoint12(currentSetpoint12),
   .setpointMv12(setpointMv12), .chargeOn(chargeOn), .slowDecayOn(slowDecayOn),
   .fastDecayOn(fastDecayOn)
);
`default_nettype wire

// >>> dv/ssc_host_model.sv
// serial settings host and step clock source model
`timescale 1ns/1ps
`default_nettype none
module ssc_host_model (
   input wire logic clock,
   output logic frameStart,
   output logic sclRise,
   output logic sdaIn,
   output logic stepClkIn
);
   initial begin
      frameStart = 1'b0;
      sclRise = 1'b0;
      sdaIn = 1'b0;
      stepClkIn = 1'b0;
   end
   // msb first; returns at the edge that samples the last bit
   task automatic sendBits(input logic [7:0] b, input int n);
      @(posedge clock) frameStart <= 1'b1;
      @(posedge clock) frameStart <= 1'b0;
      for (int i = 0; i < n; i++) begin
         if (i > 0) @(posedge clock);
         sclRise <= 1'b1;
         sdaIn <= b[7-i];
         @(posedge clock);
         sclRise <= 1'b0;
         // released line must not keep the last bit
         sdaIn <= ~b[7-i];
      end
   endtask
   task automatic ack();
      @(posedge clock) sclRise <= 1'b1;
      @(posedge clock) sclRise <= 1'b0;
   endtask
   task automatic steps(input int n);
      repeat (n) begin
         @(posedge clock) stepClkIn <= 1'b1;
         @(posedge clock) stepClkIn <= 1'b0;
      end
   endtask
   task automatic level(input logic v);
      @(posedge clock) stepClkIn <= v;
   endtask
endmodule
`default_nettype wire

// >>> dv/test_ssc_stepper_chopper.sv
// self-checking bench for the stepper settings and chopper block
`timescale 1ns/1ps
`default_nettype none
module test_ssc_stepper_chopper;
   logic clock, reset, frameStart, sclRise, sdaIn, stepClkIn, coilBelowSetpoint;
   logic internalStepClk, holdActive, counterResetActive, chopFreqSlow;
   logic chargeOn, slowDecayOn, fastDecayOn;
   logic [1:0] divRatioSel;
   logic [3:0] currentSetpoint12, currentSetpoint34;
   logic [7:0] position, setpointMv12, setpointMv34;
   int miscompares = 0;
   int samples_checked = 0;
   int cycles = 0;
   ssc_stepper_chopper #(.FORCED_CYC(4), .SLOW_CYC(8)) ssc_stepper_chopper_i (
      .clock(clock), .reset(reset), .frameStart(frameStart), .sclRise(sclRise),
      .sdaIn(sdaIn), .stepClkIn(stepClkIn), .coilBelowSetpoint(coilBelowSetpoint),
      .internalStepClk(internalStepClk), .holdActive(holdActive),
      .counterResetActive(counterResetActive), .divRatioSel(divRatioSel),
      .position(position), .currentSetpoint12(currentSetpoint12),
      .currentSetpoint34(currentSetpoint34), .setpointMv12(setpointMv12),
      .setpointMv34(setpointMv34), .chopFreqSlow(chopFreqSlow), .chargeOn(chargeOn),
      .slowDecayOn(slowDecayOn), .fastDecayOn(fastDecayOn));
   ssc_host_model ssc_host_model_i (.clock(clock), .frameStart(frameStart),
      .sclRise(sclRise), .sdaIn(sdaIn), .stepClkIn(stepClkIn));
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %s exp %h got %h", name, exp, got);
      end
   endtask
   task automatic put(input logic [7:0] b);
      ssc_host_model_i.sendBits(b, 8);
      ssc_host_model_i.ack();
      repeat (2) @(posedge clock);
      #1;
   endtask
   task automatic testHold();
      logic [7:0] p;
      ssc_host_model_i.sendBits(8'h01, 8);
      #1;
      chk("hold early", 8'h00, {7'h0, holdActive});
      @(posedge clock);
      #1;
      chk("hold", 8'h01, {7'h0, holdActive});
      p = position;
      ssc_host_model_i.steps(3);
      #1;
      chk("held pos", p, position);
      chk("held low", 8'h00, {7'h0, internalStepClk});
      put(8'h00);
      chk("release", 8'h00, {7'h0, holdActive});
      ssc_host_model_i.level(1'b1);
      put(8'h01);
      p = position;
      ssc_host_model_i.steps(2);
      @(posedge clock);
      #1;
      chk("held high", 8'h01, {7'h0, internalStepClk});
      chk("held pos 2", p, position);
      put(8'h00);
   endtask
   task automatic testCounter();
      ssc_host_model_i.steps(3);
      put(8'h21);
      chk("reset pos", 8'h00, position);
      chk("cnt reset", 8'h01, {7'h0, counterResetActive});
      ssc_host_model_i.steps(2);
      #1;
      chk("reset stays", 8'h00, position);
      put(8'h20);
      chk("cnt release", 8'h00, {7'h0, counterResetActive});
      ssc_host_model_i.steps(1);
      repeat (2) @(posedge clock);
      #1;
      chk("resume", 8'h01, position);
   endtask
   task automatic testDivider();
      logic [7:0] p;
      for (int d = 0; d < 4; d++) begin
         put(8'h40 | 8'(d));
         p = position;
         ssc_host_model_i.steps(8);
         repeat (2) @(posedge clock);
         #1;
         chk("div pos", p + 8'(8 >> d), position);
      end
      put(8'h40);
   endtask
   task automatic testSetpoint();
      for (int c = 0; c < 16; c++) begin
         put(8'h60 | 8'(c));
         put(8'h80 | 8'(15 - c));
         chk("ref12", 8'(c), {4'h0, currentSetpoint12});
         chk("ref34", 8'(15 - c), {4'h0, currentSetpoint34});
         chk("mv12", 8'(200 - 10 * c), setpointMv12);
         chk("mv34", 8'(50 + 10 * c), setpointMv34);
      end
      // a cut-short byte and an unused select must change nothing
      ssc_host_model_i.sendBits(8'h60, 7);
      put(8'hC0);
      chk("partial", 8'h0F, {4'h0, currentSetpoint12});
   endtask
   task automatic chopPeriod(input logic below, input int len);
      int c, s, f, n;
      logic prev;
      c = 0;
      s = 0;
      f = 0;
      for (n = 0; n < 300 && chargeOn !== 1'b0; n++) begin
         @(posedge clock);
         #1;
      end
      @(posedge clock);
      coilBelowSetpoint <= below;
      #1;
      for (n = 0; n < 300 && chargeOn !== 1'b1; n++) begin
         @(posedge clock);
         #1;
      end
      prev = 1'b1;
      for (n = 0; n < 300 && !(chargeOn && !prev); n++) begin
         c += chargeOn;
         s += slowDecayOn;
         f += fastDecayOn;
         prev = chargeOn;
         @(posedge clock);
         coilBelowSetpoint <= below && c + s + f < 20;
         #1;
      end
      chk("slow len", below ? 8'h08 : 8'h00, 8'(s));
      if (!below) chk("forced", 8'h04, 8'(c));
      chk("period", 8'(len), 8'(c + s + f));
   endtask
   task automatic testChop();
      chopPeriod(1'b1, 125);
      chopPeriod(1'b0, 125);
      put(8'hA1);
      chk("chop slow", 8'h01, {7'h0, chopFreqSlow});
      chopPeriod(1'b1, 250);
   endtask
   task automatic print_verdict();
      $display("compares %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         print_verdict();
      end
   end
   initial begin
      reset = 1'b1;
      coilBelowSetpoint = 1'b0;
      repeat (3) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      #1;
      chk("rst mv", 8'hC8, setpointMv12);
      chk("rst div", 8'h00, {6'h0, divRatioSel});
      testHold();
      testCounter();
      testDivider();
      testSetpoint();
      testChop();
      print_verdict();
   end
endmodule
`default_nettype wire
